// File: phy_mgmt_regs.svh
`ifndef PHY_MGMT_REGS_SVH
`define PHY_MGMT_REGS_SVH

// Register addresses inside the vendor device.
`define VENDOR_DEVAD 5'h1E
`define ADDR_SUBSYS_RST 16'h8814
`define ADDR_MAC_IF_RST 16'h8815
`define ADDR_SYS_STATUS 16'h8818
`define ADDR_PMG_CNTRL 16'h8819
`define ADDR_DIAG_CLK 16'h882C
`define ADDR_PKG_INFO 16'h8C22
`define ADDR_GRP_CNTRL 16'h8C30

// Field positions and fixed values.
`define BIT_TRIGGER 0
`define BIT_STARTUP_DONE 0
`define BIT_POWERDOWN 1
`define BIT_FORCE_OSC 0
`define BIT_DIAG_EN 0
`define BIT_GRP_EN 0
`define PKG_CODE_W 6
`define DIAG_CLK_FIXED 16'h0002
`define GROUP_PORT_ADDR 5'h1F

// Management frame encoding.
`define ST_BIT 1'h0
`define OP_ADDRESS 2'h0
`define OP_WRITE 2'h1
`define OP_READ_INC 2'h2
`define OP_READ 2'h3
`define PREAMBLE_ONES 6'h20
`define HDR_LAST_BIT 5'h0C
`define HDR_ST_POS 12
`define HDR_OP_MSB 11
`define HDR_OP_LSB 10
`define HDR_PRT_MSB 9
`define HDR_PRT_LSB 5
`define HDR_DEV_MSB 4
`define HDR_DEV_LSB 0
`define DATA_LAST_BIT 5'h0F

// Sequencer timing.
`define CLK_PERIOD_NS 8
`define STARTUP_NS 10000
`define SUBSYS_RST_NS 1000
`define MAC_IF_RST_NS 400

`endif

// File: phy_mgmt_pkg.sv
package phy_mgmt_pkg;

  typedef enum logic [3:0] {
    F_PRE = 4'h1,
    F_HDR = 4'h2,
    F_TA = 4'h4,
    F_DATA = 4'h8
  } frame_state_t;

  typedef enum logic [3:0] {
    S_START = 4'h1,
    S_RUN = 4'h2,
    S_SUBRST = 4'h4,
    S_MACRST = 4'h8
  } seq_state_t;

  typedef struct packed {
    logic mdc;
    logic mdio;
  } mdio_in_t;

  typedef struct packed {
    logic mdio_out;
    logic mdio_oe_n;
  } mdio_out_t;

  typedef struct packed {
    frame_state_t fs;
    logic [5:0] ones;
    logic [4:0] cnt;
    logic [15:0] sh;
    logic [1:0] op;
    logic hit;
    logic mdc;
    logic drive;
    logic dout;
    logic [15:0] addr;
    logic sub_trig;
    logic mac_trig;
    logic force_osc;
    logic diag_en;
    logic grp_en;
    seq_state_t seq;
    logic [15:0] tmr;
  } mgmt_state_t;

endpackage

// File: phy_reset_clock_mgmt_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "phy_mgmt_regs.svh"

// Behaviour
// - subsystem reset trigger pulses reset, self-clears
// - MAC interface reset trigger pulses reset, self-clears
// - status bit zero shows start-up done
// - status bit one shows software power-down
// - read-write bit forces boot oscillator on
// - diagnostics clock enable bit, reads 0x0002 with it clear
// - six-bit read-only package type code
// - group mode accepts writes/address ops to 31
// - registers stay reachable during power-down
module phy_reset_clock_mgmt_regs
  import phy_mgmt_pkg::*;
#(
  parameter logic [5:0] PACKAGE_TYPE = 6'h00
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire mdio_in_t mgmt_in,
  output var mdio_out_t mgmt_out,
  input wire logic [4:0] port_address,
  input wire logic powerdown_state_flag,
  output logic subsystem_reset,
  output logic mac_interface_reset,
  output logic startup_done_flag,
  output logic force_boot_oscillator,
  output logic diagnostics_clock_enable
);

  localparam int STARTUP_CYC =
    (`STARTUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int SUBRST_CYC =
    (`SUBSYS_RST_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int MACRST_CYC =
    (`MAC_IF_RST_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam logic [15:0] STARTUP_T = 16'(STARTUP_CYC - 1);
  localparam logic [15:0] SUBRST_T = 16'(SUBRST_CYC - 1);
  localparam logic [15:0] MACRST_T = 16'(MACRST_CYC - 1);

  mgmt_state_t s_q;
  mgmt_state_t s_d;

  logic rise;
  logic bit_in;
  logic [15:0] sh_new;
  logic [1:0] hdr_op;
  logic [4:0] hdr_prt;
  logic [4:0] hdr_dev;
  logic hdr_read;
  logic hdr_hit;

  function automatic logic [15:0] read_reg(input mgmt_state_t s,
                                           input logic pd);
    logic [15:0] v;
    v = 16'h0000;
    unique case (s.addr)
      `ADDR_SUBSYS_RST: v[`BIT_TRIGGER] = s.sub_trig;
      `ADDR_MAC_IF_RST: v[`BIT_TRIGGER] = s.mac_trig;
      `ADDR_SYS_STATUS: begin
        v[`BIT_STARTUP_DONE] = (s.seq == S_RUN);
        v[`BIT_POWERDOWN] = pd;
      end
      `ADDR_PMG_CNTRL: v[`BIT_FORCE_OSC] = s.force_osc;
      `ADDR_DIAG_CLK: begin
        v = `DIAG_CLK_FIXED;
        v[`BIT_DIAG_EN] = s.diag_en;
      end
      `ADDR_PKG_INFO: v[`PKG_CODE_W-1:0] = PACKAGE_TYPE;
      `ADDR_GRP_CNTRL: v[`BIT_GRP_EN] = s.grp_en;
      default: v = 16'h0000;
    endcase
    return v;
  endfunction

  always_comb begin
    rise = mgmt_in.mdc && !s_q.mdc;
    bit_in = mgmt_in.mdio;
    sh_new = {s_q.sh[14:0], bit_in};
    hdr_op = sh_new[`HDR_OP_MSB:`HDR_OP_LSB];
    hdr_prt = sh_new[`HDR_PRT_MSB:`HDR_PRT_LSB];
    hdr_dev = sh_new[`HDR_DEV_MSB:`HDR_DEV_LSB];
    hdr_read = (hdr_op == `OP_READ) || (hdr_op == `OP_READ_INC);
    // group address accepted for writes and address ops
    // reads only answer the own port address
    hdr_hit = (sh_new[`HDR_ST_POS] == `ST_BIT) &&
              (hdr_dev == `VENDOR_DEVAD) &&
              ((hdr_prt == port_address) ||
               (s_q.grp_en && !hdr_read && hdr_prt == `GROUP_PORT_ADDR));
  end

  always_comb begin
    s_d = s_q;
    s_d.mdc = mgmt_in.mdc;

    // Sequencer runs first so that a same-cycle write of a trigger wins.
    unique case (s_q.seq)
      S_START: begin
        if (s_q.tmr == 16'h0000) begin
          s_d.seq = S_RUN;
        end else begin
          s_d.tmr = s_q.tmr - 16'h0001;
        end
      end
      S_RUN: begin
        if (s_q.sub_trig) begin
          s_d.seq = S_SUBRST;
          s_d.tmr = SUBRST_T;
        end else if (s_q.mac_trig) begin
          s_d.seq = S_MACRST;
          s_d.tmr = MACRST_T;
        end
      end
      S_SUBRST: begin
        if (s_q.tmr == 16'h0000) begin
          s_d.seq = S_RUN;
          s_d.sub_trig = 1'b0;
        end else begin
          s_d.tmr = s_q.tmr - 16'h0001;
        end
      end
      S_MACRST: begin
        // hold MAC interface reset, then self-clear
        if (s_q.tmr == 16'h0000) begin
          s_d.seq = S_RUN;
          s_d.mac_trig = 1'b0;
        end else begin
          s_d.tmr = s_q.tmr - 16'h0001;
        end
      end
    endcase

    // the frame engine is never gated by power-down.
    if (rise) begin
      unique case (s_q.fs)
        F_PRE: begin
          if (bit_in) begin
            if (s_q.ones != `PREAMBLE_ONES) begin
              s_d.ones = s_q.ones + 6'h01;
            end
          end else if (s_q.ones == `PREAMBLE_ONES) begin
            s_d.fs = F_HDR;
            s_d.cnt = 5'h00;
            s_d.sh = 16'h0000;
          end else begin
            s_d.ones = 6'h00;
          end
        end
        F_HDR: begin
          s_d.sh = sh_new;
          s_d.cnt = s_q.cnt + 5'h01;
          if (s_q.cnt == `HDR_LAST_BIT) begin
            s_d.fs = F_TA;
            s_d.cnt = 5'h00;
            s_d.op = hdr_op;
            s_d.hit = hdr_hit;
            s_d.sh = read_reg(s_q, powerdown_state_flag);
          end
        end
        F_TA: begin
          s_d.cnt = s_q.cnt + 5'h01;
          if (s_q.op == `OP_READ || s_q.op == `OP_READ_INC) begin
            s_d.drive = s_q.hit;
          end
          s_d.dout = 1'b0;
          if (s_q.cnt != 5'h00) begin
            s_d.fs = F_DATA;
            s_d.cnt = 5'h00;
            s_d.dout = s_q.sh[15];
            s_d.sh = {s_q.sh[14:0], 1'b0};
          end
        end
        F_DATA: begin
          s_d.sh = sh_new;
          s_d.dout = s_q.sh[15];
          s_d.cnt = s_q.cnt + 5'h01;
          if (s_q.cnt == `DATA_LAST_BIT) begin
            s_d.fs = F_PRE;
            s_d.ones = 6'h00;
            s_d.drive = 1'b0;
            if (s_q.hit) begin
              unique case (s_q.op)
                `OP_ADDRESS: s_d.addr = sh_new;
                `OP_READ_INC: s_d.addr = s_q.addr + 16'h0001;
                `OP_READ: s_d.addr = s_q.addr;
                `OP_WRITE: begin
                  unique case (s_q.addr)
                    `ADDR_SUBSYS_RST:
                      if (sh_new[`BIT_TRIGGER]) s_d.sub_trig = 1'b1;
                    `ADDR_MAC_IF_RST:
                      if (sh_new[`BIT_TRIGGER]) s_d.mac_trig = 1'b1;
                    `ADDR_PMG_CNTRL:
                      s_d.force_osc = sh_new[`BIT_FORCE_OSC];
                    `ADDR_DIAG_CLK: s_d.diag_en = sh_new[`BIT_DIAG_EN];
                    // host sets and clears group mode
                    `ADDR_GRP_CNTRL: s_d.grp_en = sh_new[`BIT_GRP_EN];
                    default: s_d.addr = s_q.addr;
                  endcase
                end
              endcase
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      // Clock history starts high so a high clock at release is no edge.
      s_q <= '{fs: F_PRE, seq: S_START, tmr: STARTUP_T, mdc: 1'b1,
               default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  always_comb begin
    mgmt_out.mdio_out = s_q.dout;
    mgmt_out.mdio_oe_n = !s_q.drive;
    subsystem_reset = (s_q.seq == S_SUBRST);
    mac_interface_reset = (s_q.seq == S_MACRST);
    startup_done_flag = (s_q.seq == S_RUN);
    force_boot_oscillator = s_q.force_osc;
    diagnostics_clock_enable = s_q.diag_en;
  end

endmodule
`default_nettype wire

// File: reset_watch_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module reset_watch
  import phy_mgmt_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire mdio_in_t mgmt_in,
  input wire logic subsystem_reset,
  input wire logic mac_interface_reset,
  input wire logic startup_done_flag,
  input wire logic force_boot_oscillator,
  input wire logic diagnostics_clock_enable
);
  logic [7:0] sub_q;
  logic [7:0] mac_q;
  logic [11:0] up_q;
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // Pulse lengths are counted here because they exceed a repetition.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sub_q <= 8'h00;
      mac_q <= 8'h00;
      up_q <= 12'h000;
    end else begin
      sub_q <= subsystem_reset ? sub_q + 8'h01 : 8'h00;
      mac_q <= mac_interface_reset ? mac_q + 8'h01 : 8'h00;
      up_q <= (up_q == 12'hFFF) ? up_q : up_q + 12'h001;
    end
  end
  a_sub_len: assert property ($fell(subsystem_reset) |-> sub_q == 8'h7D)
    else $error("subsystem pulse length");
  a_mac_len: assert property (
    $fell(mac_interface_reset) |-> mac_q == 8'h32)
    else $error("mac pulse length");
  a_rst_apart: assert property (
    !(subsystem_reset && mac_interface_reset))
    else $error("resets overlap");
  a_ready_low: assert property (
    (subsystem_reset || mac_interface_reset) |-> !startup_done_flag)
    else $error("ready during reset");
  a_ready_early: assert property (up_q < 12'h4D8 |-> !startup_done_flag)
    else $error("ready too early");
  a_osc_edge: assert property (
    $changed(force_boot_oscillator) |->
      $past(mgmt_in.mdc) && !$past(mgmt_in.mdc, 2))
    else $error("oscillator bit moved off a write");
  a_diag_edge: assert property (
    $changed(diagnostics_clock_enable) |->
      $past(mgmt_in.mdc) && !$past(mgmt_in.mdc, 2))
    else $error("diag bit moved off a write");
  a_ready_late: assert property (up_q == 12'h4EC |-> startup_done_flag)
    else $error("ready too late");
  c_sub: cover property ($fell(subsystem_reset));
  c_mac: cover property ($fell(mac_interface_reset));
  c_osc: cover property ($rose(force_boot_oscillator));
endmodule
bind phy_reset_clock_mgmt_regs reset_watch reset_watch_i (.clock(clock),
  .sys_rst(sys_rst), .mgmt_in(mgmt_in), .subsystem_reset(subsystem_reset),
  .mac_interface_reset(mac_interface_reset),
  .startup_done_flag(startup_done_flag),
  .force_boot_oscillator(force_boot_oscillator),
  .diagnostics_clock_enable(diagnostics_clock_enable));
`default_nettype wire

// File: mdio_station.sv
`timescale 1ns/1ps
`default_nettype none
module mdio_station
  import phy_mgmt_pkg::*;
(
  input wire logic clock,
  input wire mdio_out_t dev,
  output var mdio_in_t bus
);
  logic mdc = 1'b0;
  logic en = 1'b0;
  logic v = 1'b1;
  // The wire is pulled up, so a released line reads one.
  assign bus = {mdc, !dev.mdio_oe_n ? dev.mdio_out : (en ? v : 1'b1)};
  task automatic cyc(input logic e, input logic b, output logic s);
    #1 mdc = 1'b0;
    en = e;
    v = b;
    repeat (2) @(posedge clock);
    s = bus.mdio;
    #1 mdc = 1'b1;
    repeat (2) @(posedge clock);
  endtask
  task automatic frame(input logic [1:0] op, input logic [4:0] pa,
      input logic [15:0] d, output logic [15:0] q);
    logic [13:0] h;
    logic s;
    h = {2'h0, op, pa, 5'h1E};
    repeat (32) cyc(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--) cyc(1'b1, h[i], s);
    cyc(!op[1], 1'b1, s);
    cyc(!op[1], 1'b0, s);
    for (int i = 15; i >= 0; i--) begin
      cyc(!op[1], d[i], s);
      q[i] = s;
    end
    #1 en = 1'b0;
  endtask
endmodule
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import phy_mgmt_pkg::*;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic pd = 1'b0;
  logic [4:0] pa = 5'h00;
  mdio_in_t mi;
  mdio_out_t mo;
  logic sr, mr, rdy, osc, dg;
  logic [15:0] q, got;
  logic [15:0] notes[$];
  int miscompares = 0;
  int n_checks = 0;
  int seed = 734;
  event ev;
  always #4 clock = ~clock;
  phy_reset_clock_mgmt_regs #(.PACKAGE_TYPE(6'h2A))
    phy_reset_clock_mgmt_regs_i (.clock(clock), .sys_rst(sys_rst),
    .mgmt_in(mi), .mgmt_out(mo), .port_address(pa),
    .powerdown_state_flag(pd), .subsystem_reset(sr),
    .mac_interface_reset(mr), .startup_done_flag(rdy),
    .force_boot_oscillator(osc), .diagnostics_clock_enable(dg));
  mdio_station mdio_station_i (.clock(clock), .dev(mo), .bus(mi));
  task automatic report_and_stop();
    if (miscompares == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic rd(input logic [4:0] p, input logic [15:0] a, e);
    mdio_station_i.frame(2'h0, p, a, q);
    mdio_station_i.frame(2'h3, p, 16'h0000, q);
    notes.push_back(e);
    got = q;
    -> ev;
  endtask
  task automatic wr(input logic [4:0] p, input logic [15:0] a, d);
    mdio_station_i.frame(2'h0, p, a, q);
    mdio_station_i.frame(2'h1, p, d, q);
  endtask
  task automatic lvl(input logic [2:0] b, e);
    #1 notes.push_back({13'h0000, e});
    got = {13'h0000, b};
    -> ev;
  endtask
  task automatic trig(input logic [15:0] a, input logic [2:0] e);
    wr(pa, a, 16'h0001);
    repeat (4) @(posedge clock);
    lvl({sr, mr, rdy}, e);
    rd(pa, a, 16'h0000);
    lvl({sr, mr, rdy}, 3'h1);
  endtask
  always @(ev) begin
    n_checks++;
    if (got !== notes.pop_front()) begin
      miscompares++;
      $display("[FAIL] %0t value %h", $time, got);
    end
  end
  initial begin
    #400000 miscompares++;
    report_and_stop();
  end
  initial begin
    repeat (3) @(posedge clock);
    #1 sys_rst = 1'b0;
    pa = 5'($random(seed)) & 5'h0F;
    pd = 1'($random(seed));
    for (int i = 0; i < 1400 && rdy !== 1'b1; i++) @(posedge clock);
    lvl({2'h0, rdy}, 3'h1);
    rd(pa, 16'h8814, 16'h0000);
    rd(pa, 16'h8815, 16'h0000);
    rd(pa, 16'h8818, {14'h0000, pd, 1'b1});
    pd = ~pd;
    rd(pa, 16'h8818, {14'h0000, pd, 1'b1});
    rd(pa, 16'h8819, 16'h0000);
    rd(pa, 16'h882C, 16'h0002);
    wr(pa, 16'h8C22, 16'hFFFF);
    rd(pa, 16'h8C22, 16'h002A);
    rd(pa, 16'h8C30, 16'h0000);
    rd(pa, 16'h8800, 16'h0000);
    wr(pa, 16'h8819, 16'hFFFF);
    rd(pa, 16'h8819, 16'h0001);
    lvl({2'h0, osc}, 3'h1);
    // Read-increment returns the status word and steps to the next one.
    mdio_station_i.frame(2'h0, pa, 16'h8818, q);
    mdio_station_i.frame(2'h2, pa, 16'h0000, q);
    notes.push_back({14'h0000, pd, 1'b1});
    got = q;
    -> ev;
    mdio_station_i.frame(2'h3, pa, 16'h0000, q);
    notes.push_back(16'h0001);
    got = q;
    -> ev;
    wr(pa, 16'h882C, 16'hFFFF);
    rd(pa, 16'h882C, 16'h0003);
    lvl({2'h0, dg}, 3'h1);
    trig(16'h8814, 3'h4);
    trig(16'h8815, 3'h2);
    wr(pa, 16'h8C30, 16'h0001);
    wr(5'h1F, 16'h8819, 16'h0000);
    lvl({2'h0, osc}, 3'h0);
    rd(5'h1F, 16'h8819, 16'hFFFF);
    // Group mode stays on only for the broadcast setup burst.
    wr(pa, 16'h8C30, 16'h0000);
    wr(5'h1F, 16'h8819, 16'h0001);
    lvl({2'h0, osc}, 3'h0);
    // Let the checking process take the last note before the verdict.
    repeat (2) @(posedge clock);
    report_and_stop();
  end
endmodule
`default_nettype wire
